// ### rotate_and_bit_shift_unit.v
// rotate and bit-shift execution unit
`timescale 1ns/10ps
`include "rot_shift_defs.vh"
module rotate_and_bit_shift_unit #(
  parameter DEPTH = 1024,
  parameter AW    = 10
) (
  input  wire          core_clk_i,
  input  wire          reset_i,
  input  wire          scan_tick_i,
  input  wire          drive_i,
  input  wire          continuous_i,
  input  wire [2:0]    opcode_i,
  input  wire          double_word_i,
  input  wire          bit_group_i,
  input  wire [3:0]    group_digits_i,
  input  wire [5:0]    rotate_count_i,
  input  wire [31:0]   rotate_word_i,
  input  wire [10:0]   buffer_length_i,
  input  wire [10:0]   shift_count_i,
  input  wire [AW-1:0] src_addr_i,
  input  wire [AW-1:0] dst_addr_i,
  input  wire          src_wr_i,
  input  wire [AW-1:0] src_wr_addr_i,
  input  wire          src_wr_data_i,
  input  wire [AW-1:0] dst_rd_addr_i,
  output reg  [31:0]   rotate_result_o,
  output reg           carry_flag_o,
  output reg           operand_error_o,
  output wire          busy_o,
  output reg           done_o,
  output wire          dst_rd_data_o
);
  localparam S_IDLE = 4'h1;
  localparam S_READ = 4'h2;
  localparam S_WAIT = 4'h4;
  localparam S_WRIT = 4'h8;

  reg  [3:0]    state_ff;
  reg           drive_prev_ff;
  reg  [10:0]   idx_ff;
  reg           dir_left_ff;
  reg  [10:0]   len_ff;
  reg  [10:0]   cnt_ff;
  reg  [AW-1:0] src_ff;
  reg  [AW-1:0] dst_ff;
  reg  [31:0]   nxt_word;
  reg           nxt_carry;
  reg           rot_ok;
  reg           shift_ok;
  reg  [5:0]    k;
  integer       i;

  // address arithmetic shared by read and write paths
  function [AW-1:0] offs;
    input [AW-1:0] base;
    input [10:0]   off;
    begin
      offs = base + off[AW-1:0];
    end
  endfunction

  // execution trigger: edge in pulse form, every scan in continuous form
  wire rise  = drive_i & ~drive_prev_ff;
  wire fire  = scan_tick_i & (continuous_i ? drive_i : rise);
  wire is_rot = ~opcode_i[2];

  // operand checks on count and group width
  always @* begin
    rot_ok = (rotate_count_i <= (double_word_i ? `DOUBLE_WORD_MAX : `SINGLE_WORD_MAX));
    if (bit_group_i) begin
      rot_ok = rot_ok & (group_digits_i ==
               (double_word_i ? `GROUP_THIRTY_TWO : `GROUP_SIXTEEN));
    end
    shift_ok = (buffer_length_i != 11'h000) && (buffer_length_i <= `BUFFER_LENGTH_MAX) &&
               (shift_count_i != 11'h000) && (shift_count_i <= buffer_length_i);
  end

  // bit-serial rotation, carry either beside or inside the ring
  always @* begin
    nxt_word  = rotate_word_i;
    nxt_carry = carry_flag_o;
    k         = rotate_count_i;
    for (i = 0; i < 32; i = i + 1) begin
      if (i < k) begin
        case (opcode_i)
          `OP_ROTATE_LEFT: begin
            nxt_carry = double_word_i ? nxt_word[31] : nxt_word[15];
            if (double_word_i) nxt_word = {nxt_word[30:0], nxt_word[31]};
            else nxt_word = {16'h0000, nxt_word[14:0], nxt_word[15]};
          end
          `OP_ROTATE_RIGHT: begin
            nxt_carry = nxt_word[0];
            if (double_word_i) nxt_word = {nxt_word[0], nxt_word[31:1]};
            else nxt_word = {16'h0000, nxt_word[0], nxt_word[15:1]};
          end
          `OP_ROTATE_LEFT_CARRY: begin
            if (double_word_i) begin
              {nxt_carry, nxt_word} = {nxt_word, nxt_carry};
            end else begin
              {nxt_carry, nxt_word[15:0]} = {nxt_word[15:0], nxt_carry};
            end
          end
          `OP_ROTATE_RIGHT_CARRY: begin
            if (double_word_i) begin
              {nxt_word, nxt_carry} = {nxt_carry, nxt_word};
            end else begin
              {nxt_word[15:0], nxt_carry} = {nxt_carry, nxt_word[15:0]};
            end
          end
          default: begin
            nxt_word = nxt_word;
          end
        endcase
      end
    end
    if (!double_word_i) nxt_word[31:16] = 16'h0000;
  end

  // shift datapath: one element per three cycles through the buffer
  wire [10:0]   keep   = len_ff - cnt_ff;
  wire          from_src = dir_left_ff ? (idx_ff < cnt_ff) : (idx_ff >= keep);
  wire [AW-1:0] rd_addr = from_src ?
                 offs(src_ff, dir_left_ff ? idx_ff : idx_ff - keep) :
                 offs(dst_ff, dir_left_ff ? idx_ff - cnt_ff : idx_ff + cnt_ff);
  wire          buf_rd;
  wire          src_rd;
  reg           dst_wr_en_ff;
  reg  [AW-1:0] dst_wr_addr_ff;
  reg           dst_wr_data_ff;
  reg           rd_src_ff;

  assign busy_o = ~state_ff[0];

  // sequencer and rotate result registers
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      state_ff <= S_IDLE;
      drive_prev_ff <= 1'b0;
      idx_ff <= 11'h000;
      dir_left_ff <= 1'b0;
      len_ff <= 11'h000;
      cnt_ff <= 11'h000;
      src_ff <= {AW{1'b0}};
      dst_ff <= {AW{1'b0}};
      rotate_result_o <= 32'h00000000;
      carry_flag_o <= `CARRY_RESET;
      operand_error_o <= 1'b0;
      done_o <= 1'b0;
      dst_wr_en_ff <= 1'b0;
      dst_wr_addr_ff <= {AW{1'b0}};
      dst_wr_data_ff <= 1'b0;
      rd_src_ff <= 1'b0;
    end else begin
      done_o <= 1'b0;
      dst_wr_en_ff <= 1'b0;
      if (scan_tick_i) drive_prev_ff <= drive_i;
      case (state_ff)
        S_IDLE: begin
          if (fire && is_rot) begin
            operand_error_o <= ~rot_ok;
            if (rot_ok) begin
              rotate_result_o <= nxt_word;
              carry_flag_o <= nxt_carry;
            end
            done_o <= 1'b1;
          end else if (fire) begin
            operand_error_o <= ~shift_ok;
            if (shift_ok) begin
              dir_left_ff <= opcode_i[0];
              len_ff <= buffer_length_i;
              cnt_ff <= shift_count_i;
              src_ff <= src_addr_i;
              dst_ff <= dst_addr_i;
              idx_ff <= opcode_i[0] ? buffer_length_i - 11'h001 : 11'h000;
              state_ff <= S_READ;
            end else begin
              done_o <= 1'b1;
            end
          end
        end
        S_READ: begin
          rd_src_ff <= from_src;
          state_ff <= S_WAIT;
        end
        S_WAIT: begin
          state_ff <= S_WRIT;
        end
        S_WRIT: begin
          dst_wr_en_ff <= 1'b1;
          dst_wr_addr_ff <= offs(dst_ff, idx_ff);
          dst_wr_data_ff <= rd_src_ff ? src_rd : buf_rd;
          if (dir_left_ff ? (idx_ff == 11'h000) : (idx_ff == len_ff - 11'h001)) begin
            state_ff <= S_IDLE;
            done_o <= 1'b1;
          end else begin
            idx_ff <= dir_left_ff ? idx_ff - 11'h001 : idx_ff + 11'h001;
            state_ff <= S_READ;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // destination buffer, read by the shifter or by the user port when idle
  bit_buffer_mem #(.DEPTH(DEPTH), .AW(AW)) u_dst (
    .core_clk_i (core_clk_i),
    .wr_en_i    (dst_wr_en_ff),
    .wr_addr_i  (dst_wr_addr_ff),
    .wr_data_i  (dst_wr_data_ff),
    .rd_addr_i  (busy_o ? rd_addr : dst_rd_addr_i),
    .rd_data_o  (buf_rd)
  );

  // source bit range, loaded by the user
  bit_buffer_mem #(.DEPTH(DEPTH), .AW(AW)) u_src (
    .core_clk_i (core_clk_i),
    .wr_en_i    (src_wr_i),
    .wr_addr_i  (src_wr_addr_i),
    .wr_data_i  (src_wr_data_i),
    .rd_addr_i  (rd_addr),
    .rd_data_o  (src_rd)
  );

  assign dst_rd_data_o = buf_rd;
endmodule // rotate_and_bit_shift_unit

// ### rot_shift_defs.vh
// constants for the rotate and bit-shift execution unit
// Operation
// - rotate count is at most 16 single-word, 32 double-word; word rotates that far
// - left rotate without carry copies last wrapped-out bit to carry flag
// - right rotate without carry copies last wrapped-out bit to carry flag
// - continuous rotate repeats once every scan cycle while drive holds
// - bit-group destinations accept only sixteen or thirty-two bit groups
// - through-carry rotates put the carry flag inside the rotating ring
// - double-word rotates behave like single-word ones over 32 bits
// - bit-shift buffer length is 1 to 1024 elements from destination start
// - shift count is at least 1 and at most the buffer length
// - shift moves buffer, drops pushed-out bits, refills from source bits
// - continuous bit shift runs one full shift every scan cycle while driven; scan ticks that come while a shift is busy are ignored
`ifndef ROT_SHIFT_DEFS_VH
`define ROT_SHIFT_DEFS_VH
`define OP_ROTATE_RIGHT       3'h0
`define OP_ROTATE_LEFT        3'h1
`define OP_ROTATE_RIGHT_CARRY 3'h2
`define OP_ROTATE_LEFT_CARRY  3'h3
`define OP_BIT_SHIFT_RIGHT    3'h4
`define OP_BIT_SHIFT_LEFT     3'h5
`define SINGLE_WORD_MAX       6'h10
`define DOUBLE_WORD_MAX       6'h20
`define BUFFER_LENGTH_MAX     11'h400
`define GROUP_SIXTEEN         4'h4
`define GROUP_THIRTY_TWO      4'h8
`define CARRY_RESET           1'h0
`endif

// ### bit_buffer_mem.v
// bit buffer memory with registered read data
`timescale 1ns/10ps
module bit_buffer_mem #(
  parameter DEPTH = 1024,
  parameter AW    = 10
) (
  input  wire          core_clk_i,
  input  wire          wr_en_i,
  input  wire [AW-1:0] wr_addr_i,
  input  wire          wr_data_i,
  input  wire [AW-1:0] rd_addr_i,
  output reg           rd_data_o
);
  reg mem [0:DEPTH-1];

  // one write port, one registered read port
  always @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // bit_buffer_mem

// ### rsu_asserts.sv
// concurrent checks on the rotate and bit-shift unit ports
`timescale 1ns/10ps
module rsu_asserts (
  input wire        core_clk_i,
  input wire        reset_i,
  input wire        scan_tick_i,
  input wire        drive_i,
  input wire        continuous_i,
  input wire [2:0]  opcode_i,
  input wire        double_word_i,
  input wire [5:0]  rotate_count_i,
  input wire [10:0] buffer_length_i,
  input wire [10:0] shift_count_i,
  input wire [31:0] rotate_result_o,
  input wire        carry_flag_o,
  input wire        operand_error_o,
  input wire        busy_o,
  input wire        done_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // a continuous-form instruction taken on this edge
  wire take = scan_tick_i & drive_i & continuous_i & !busy_o;
  wire rot  = take & (opcode_i < 3'h4);
  // rotate of nonzero count that completed without fault
  sequence s_rot(op);
    rot && opcode_i == op && rotate_count_i != 6'h0 ##1 done_o && !operand_error_o;
  endsequence
  rot_done_a: assert property (rot |=> done_o)
    else $error("rotate did not finish in one cycle");
  rol_carry_a: assert property (s_rot(3'h1) |-> carry_flag_o == rotate_result_o[0])
    else $error("left rotate carry differs from wrapped bit");
  ror_carry_a: assert property (s_rot(3'h0) |->
    carry_flag_o == ($past(double_word_i) ? rotate_result_o[31] : rotate_result_o[15]))
    else $error("right rotate carry differs from wrapped bit");
  upper_zero_a: assert property ((rot && !double_word_i ##1 done_o && !operand_error_o)
    |-> rotate_result_o[31:16] == 16'h0)
    else $error("single-word result has upper bits set");
  count_err_a: assert property (rot && !double_word_i && rotate_count_i > 6'h10
    |=> operand_error_o && done_o)
    else $error("oversized single-word count accepted");
  count32_err_a: assert property (rot && double_word_i && rotate_count_i > 6'h20
    |=> operand_error_o)
    else $error("oversized double-word count accepted");
  shift_err_a: assert property (take && opcode_i > 3'h3 && shift_count_i > buffer_length_i
    |=> operand_error_o)
    else $error("shift count above buffer length accepted");
  idle_a: assert property (!scan_tick_i && !busy_o && !$past(busy_o) |=> !done_o)
    else $error("finish pulse without an instruction");
endmodule // rsu_asserts
bind rotate_and_bit_shift_unit rsu_asserts i_rsu_asserts (.core_clk_i, .reset_i,
  .scan_tick_i, .drive_i, .continuous_i, .opcode_i, .double_word_i, .rotate_count_i,
  .buffer_length_i, .shift_count_i, .rotate_result_o, .carry_flag_o, .operand_error_o,
  .busy_o, .done_o);

// ### tb_top.sv
// self-checking bench for the rotate and bit-shift unit
`timescale 1ns/10ps
module tb_top;
  logic        core_clk_i, reset_i, scan_tick_i, drive_i, continuous_i, double_word_i;
  logic        bit_group_i, src_wr_i, src_wr_data_i, carry_flag_o, operand_error_o;
  logic        busy_o, done_o, dst_rd_data_o;
  logic [2:0]  opcode_i;
  logic [3:0]  group_digits_i;
  logic [5:0]  rotate_count_i;
  logic [31:0] rotate_word_i, rotate_result_o;
  logic [10:0] buffer_length_i, shift_count_i;
  logic [9:0]  src_addr_i, dst_addr_i, src_wr_addr_i, dst_rd_addr_i;
  int          miscompares = 0;
  int          n_tests = 0;
  localparam logic [15:0] PAT = 16'h6cb5; // source bit pattern
  rotate_and_bit_shift_unit i_dut (.core_clk_i, .reset_i, .scan_tick_i, .drive_i,
    .continuous_i, .opcode_i, .double_word_i, .bit_group_i, .group_digits_i,
    .rotate_count_i, .rotate_word_i, .buffer_length_i, .shift_count_i, .src_addr_i,
    .dst_addr_i, .src_wr_i, .src_wr_addr_i, .src_wr_data_i, .dst_rd_addr_i,
    .rotate_result_o, .carry_flag_o, .operand_error_o, .busy_o, .done_o, .dst_rd_data_o);
  // clock
  initial begin
    core_clk_i = 1'h0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      miscompares++;
    end
  endtask
  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one scan tick; returns just after the edge that takes it
  task automatic fire(input logic d, c, input logic [2:0] op, input logic dw,
                      input logic [4:0] g, input logic [5:0] n, input logic [31:0] w);
    @(posedge core_clk_i);
    scan_tick_i <= 1'h1;
    drive_i <= d;
    continuous_i <= c;
    opcode_i <= op;
    double_word_i <= dw;
    {bit_group_i, group_digits_i} <= g;
    rotate_count_i <= n;
    rotate_word_i <= w;
    @(posedge core_clk_i);
    scan_tick_i <= 1'h0;
    #1;
  endtask
  task automatic rot(input logic [2:0] op, input logic dw, input logic [4:0] g,
                     input logic [5:0] n, input logic [31:0] w, r, input logic c, e);
    fire(1'h1, 1'h1, op, dw, g, n, w);
    chk(done_o, 1'h1);
    chk(operand_error_o, e);
    chk(rotate_result_o, r);
    chk(carry_flag_o, c);
  endtask
  task automatic t_rotates;
    rot(3'h1, 1'h0, 5'h00, 6'h04, 32'h1234, 32'h2341, 1'h1, 1'h0);
    rot(3'h0, 1'h0, 5'h00, 6'h04, 32'hffff1234, 32'h4123, 1'h0, 1'h0);
    rot(3'h1, 1'h1, 5'h00, 6'h20, 32'h80000001, 32'h80000001, 1'h1, 1'h0);
    rot(3'h0, 1'h1, 5'h00, 6'h01, 32'h2, 32'h1, 1'h0, 1'h0);
    rot(3'h3, 1'h0, 5'h00, 6'h01, 32'h8001, 32'h2, 1'h1, 1'h0);
    rot(3'h2, 1'h0, 5'h00, 6'h02, 32'h2, 32'h4000, 1'h1, 1'h0);
    rot(3'h3, 1'h1, 5'h00, 6'h20, 32'h0, 32'h80000000, 1'h0, 1'h0);
    rot(3'h1, 1'h0, 5'h00, 6'h11, 32'h1234, 32'h80000000, 1'h0, 1'h1);
    rot(3'h1, 1'h0, 5'h18, 6'h04, 32'h1234, 32'h80000000, 1'h0, 1'h1);
    rot(3'h1, 1'h1, 5'h14, 6'h04, 32'h1234, 32'h80000000, 1'h0, 1'h1);
    rot(3'h1, 1'h0, 5'h14, 6'h04, 32'h1234, 32'h2341, 1'h1, 1'h0);
    rot(3'h0, 1'h1, 5'h18, 6'h04, 32'h12345678, 32'h81234567, 1'h1, 1'h0);
    rot(3'h1, 1'h1, 5'h00, 6'h21, 32'h1234, 32'h81234567, 1'h1, 1'h1);
  endtask
  // pulse form idles, fires on a rise, idles while held; continuous fires each tick
  task automatic t_forms;
    for (int i = 0; i < 5; i++) begin
      fire(i > 0, i > 2, 3'h1, 1'h0, 5'h0, 6'h4, 32'h1234);
      chk(done_o, i == 1 || i > 2);
    end
  endtask
  task automatic shift(input logic [2:0] op, input logic [10:0] len, cnt,
                       input logic [9:0] sa, da, input logic e, input logic [7:0] x);
    logic [7:0] v;
    int k;
    @(posedge core_clk_i);
    buffer_length_i <= len;
    shift_count_i <= cnt;
    src_addr_i <= sa;
    dst_addr_i <= da;
    fire(1'h1, 1'h1, op, 1'h0, 5'h0, 6'h0, 32'h0);
    chk(busy_o, !e);
    for (k = 0; k < 200 && done_o !== 1'h1; k++)
      @(posedge core_clk_i) #1;
    chk(done_o, 1'h1);
    chk(operand_error_o, e);
    for (k = 0; k < 8; k++) begin
      @(posedge core_clk_i);
      dst_rd_addr_i <= da + k[9:0];
      @(posedge core_clk_i) #1;
      v[k] = dst_rd_data_o;
    end
    chk(v, x);
  endtask
  task automatic t_shift;
    for (int k = 0; k < 16; k++) begin
      @(posedge core_clk_i);
      src_wr_i <= 1'h1;
      src_wr_addr_i <= k[9:0];
      src_wr_data_i <= PAT[k];
    end
    @(posedge core_clk_i);
    src_wr_i <= 1'h0;
    shift(3'h5, 11'h8, 11'h8, 10'h0, 10'h0, 1'h0, 8'hb5);
    shift(3'h4, 11'h8, 11'h3, 10'h8, 10'h0, 1'h0, 8'h96);
    shift(3'h5, 11'h8, 11'h1, 10'he, 10'h0, 1'h0, 8'h2d);
    shift(3'h4, 11'h8, 11'h9, 10'h0, 10'h0, 1'h1, 8'h2d);
    shift(3'h4, 11'h0, 11'h0, 10'h0, 10'h0, 1'h1, 8'h2d);
    shift(3'h5, 11'h401, 11'h1, 10'h0, 10'h0, 1'h1, 8'h2d);
    shift(3'h4, 11'h8, 11'h8, 10'h8, 10'h8, 1'h0, 8'h6c);
  endtask
  // watchdog
  initial begin
    #160000;
    miscompares++;
    stop_test;
  end
  // reset then scenarios
  initial begin
    reset_i = 1'h1;
    {scan_tick_i, drive_i, continuous_i, opcode_i, double_word_i, bit_group_i,
     group_digits_i, rotate_count_i, rotate_word_i, buffer_length_i, shift_count_i,
     src_addr_i, dst_addr_i, src_wr_i, src_wr_addr_i, src_wr_data_i, dst_rd_addr_i} = '0;
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'h0;
    t_rotates;
    t_forms;
    t_shift;
    stop_test;
  end
endmodule // tb_top
